// ### verification/dbfc_ctrl_props.sv
// assertion checker bound to the flash host controller
`timescale 1ns/1ps
module dbfc_ctrl_props #(parameter RP_CYC = 4, parameter RH_CYC = 2) (
   input wire sys_clk, // clock
   input wire nrst, // reset
   input wire rsp_valid, // read done
   input wire fl_ce_n, // select
   input wire fl_oe_n, // output enable
   input wire fl_we_n, // write enable
   input wire fl_reset_n, // flash reset
   input wire fl_word, // width pin
   input wire fl_dq_lo_oe, // host drives lines 7:0
   input wire fl_dq_hi_oe, // host drives lines 14:8
   input wire fl_top_oe // top line drive
);
   // one clock domain, so one default for all
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   rd_level_a: assert property (!fl_oe_n |-> !fl_ce_n && fl_we_n)
      else $error("read levels");
   wr_level_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n)
      else $error("write levels");
   wr_pulse_a: assert property ($fell(fl_we_n) |-> (!fl_we_n)[*8])
      else $error("short write");
   no_contend_a: assert property (!fl_oe_n
      |-> !fl_dq_lo_oe && !fl_dq_hi_oe) else $error("host drives in read");
   byte_float_a: assert property (!fl_word |-> !fl_dq_hi_oe)
      else $error("upper lanes driven in byte mode");
   byte_addr_a: assert property (!fl_word && !fl_ce_n |-> fl_top_oe)
      else $error("byte address idle");
   rst_quiet_a: assert property (!fl_reset_n |-> fl_ce_n)
      else $error("select in reset");
   rst_width_a: assert property ($rose(fl_reset_n) && $past(nrst)
      |-> !$past(fl_reset_n, RP_CYC)) else $error("short reset");
   rst_recover_a: assert property ($fell(fl_ce_n)
      |-> $past(fl_reset_n, RH_CYC)) else $error("no recovery");
   acc_wait_a: assert property (rsp_valid |-> !$past(fl_ce_n, 18))
      else $error("read too early");
   // main scenarios reached
   cover property (rsp_valid);
   cover property ($fell(fl_we_n));
   cover property ($rose(fl_reset_n) && $past(nrst));
   cover property (!fl_word && !fl_we_n);
endmodule // dbfc_ctrl_props

bind dbfc_ctrl dbfc_ctrl_props #(.RP_CYC(RP_CYC), .RH_CYC(RH_CYC)) props (.*);

// ### verification/dbfc_ctrl_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "dbfc_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module dbfc_ctrl_tb;
   logic sys_clk, nrst, req_valid, req_lsb, word_mode, req_ready, rsp_valid;
   logic bank_busy, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_word;
   logic fl_dq_lo_oe, fl_dq_hi_oe, fl_top_oe, ready_busy_n;
   logic [1:0] req_cmd;
   logic [17:0] req_addr, fl_addr, a;
   logic [15:0] req_wdata, rsp_rdata, fl_dq_out, fl_dq_in, q, d, e;
   int err_total = 0, checked = 0, cyc = 0, i;
   localparam logic [1:0] RD = `DBFC_CMD_READ, WR = `DBFC_CMD_WRITE;
   dbfc_ctrl #(.RP_CYC(4), .RH_CYC(2)) dut (.*);
   dbfc_flash_model flash (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic close_out;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // a hung handshake ends the run
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         close_out;
      end
   end
   function automatic logic [15:0] pat(input logic [17:0] x);
      return x[15:0] ^ 16'hA5C3;
   endfunction
   // one request, driven one cycle once ready is seen; reads wait for the answer
   task automatic op(input logic [1:0] c, input logic [17:0] x,
      input logic l = 1'b0, input logic [15:0] w = 16'h0000);
      @(negedge sys_clk);
      while (req_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      {req_valid, req_cmd, req_addr, req_lsb, req_wdata} <= {1'b1, c, x, l, w};
      @(posedge sys_clk);
      req_valid <= 1'b0;
      if (c == RD) begin
         @(negedge sys_clk);
         while (rsp_valid !== 1'b1) @(negedge sys_clk);
         q = rsp_rdata;
      end
   endtask
   initial begin
      {nrst, req_valid, req_cmd, req_addr, req_lsb, req_wdata} = '0;
      word_mode = 1'b1;
      i = $urandom(32'h47c21cc0);
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      for (i = 0; i < 6; i++) begin
         a = {i[0], 17'($urandom)};
         op(RD, a);
         `CHK(q, pat(a))
      end
      $display("power-up reads done");
      // program one bank, read the other while it is busy
      for (i = 0; i < 4; i++) begin
         a = {i[0], 17'($urandom)};
         d = 16'($urandom);
         op(WR, a, 1'b0, d);
         op(RD, a ^ 18'h20000);
         `CHK(q, pat(a ^ 18'h20000))
         `CHK(bank_busy, 1'b1)
         op(RD, a);
         `CHK(q, d)
      end
      $display("bank overlap done");
      @(posedge sys_clk);
      word_mode <= 1'b0;
      for (i = 0; i < 4; i++) begin
         a = 18'($urandom);
         d = 16'($urandom);
         e = pat(a);
         op(WR, a, i[0], {8'h00, d[7:0]});
         op(RD, a, ~i[0]);
         `CHK(q, {8'h00, i[0] ? e[7:0] : e[15:8]})
         op(RD, a, i[0]);
         `CHK(q, {8'h00, d[7:0]})
      end
      $display("byte width done");
      @(posedge sys_clk);
      word_mode <= 1'b1;
      // reset cuts a program short, then it is written again
      op(WR, a, 1'b0, d);
      op(`DBFC_CMD_RESET, a);
      op(RD, a);
      `CHK(q, pat(a))
      `CHK(bank_busy, 1'b0)
      op(WR, a, 1'b0, d);
      op(RD, a);
      `CHK(q, d)
      // the spare command code must start no bus cycle at all
      op(2'h3, a);
      @(negedge sys_clk);
      `CHK({fl_ce_n, fl_we_n, fl_reset_n, req_ready}, 4'hF)
      op(RD, a);
      `CHK(q, d)
      $display("reset abort done");
      close_out;
   end
endmodule // dbfc_ctrl_tb

// ### verification/dbfc_flash_model.sv
// behavioural dual bank flash on the far side of the controller
`timescale 1ns/1ps
module dbfc_flash_model #(parameter ACC_NS = 70, parameter BUSY_NS = 400) (
   input wire [17:0] fl_addr, // address
   input wire fl_ce_n, // select
   input wire fl_oe_n, // output enable
   input wire fl_we_n, // write enable
   input wire fl_reset_n, // reset
   input wire fl_word, // width
   input wire [15:0] fl_dq_out, // host data
   input wire fl_dq_lo_oe, // host drives 7:0
   input wire fl_dq_hi_oe, // host drives 14:8
   input wire fl_top_oe, // host drives top
   output logic [15:0] fl_dq_in, // wire level
   output logic ready_busy_n // low while busy
);
   logic [15:0] mem [logic [17:0]];
   logic [15:0] rd, wv;
   logic [17:0] pend;
   logic ok;
   realtime busy_end = 0;
   realtime acc_end = 0;
   wire sel = !fl_ce_n && fl_reset_n;
   wire drv = sel && !fl_oe_n && fl_we_n;
   function automatic logic [15:0] cur(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : a[15:0] ^ 16'hA5C3;
   endfunction
   // data settles one access time after address or select moves
   // a time stamp, not a delayed event, so an older move cannot end it early
   always @(fl_addr or fl_ce_n) begin
      ok = 1'b0;
      acc_end = $realtime + ACC_NS;
   end
   // lines nobody drives show the inverse, never stale data
   always @* begin
      rd = cur(fl_addr);
      if (!fl_word) rd = fl_dq_out[15] ? {~rd[15:8], rd[15:8]} :
         {~rd[7:0], rd[7:0]};
      if (!(drv && ok)) rd = ~rd;
      fl_dq_in[7:0] = fl_dq_lo_oe ? fl_dq_out[7:0] : rd[7:0];
      fl_dq_in[14:8] = fl_dq_hi_oe ? fl_dq_out[14:8] : rd[14:8];
      fl_dq_in[15] = fl_top_oe ? fl_dq_out[15] : rd[15];
   end
   // program on the rising write strobe; the embedded op runs on
   always @(posedge fl_we_n) if (sel) begin
      pend = fl_addr;
      wv = cur(fl_addr);
      if (fl_word) wv = fl_dq_out;
      else if (fl_dq_out[15]) wv[15:8] = fl_dq_out[7:0];
      else wv[7:0] = fl_dq_out[7:0];
      mem[fl_addr] = wv;
      busy_end = $realtime + BUSY_NS;
   end
   // reset aborts the op; busy stays low while it unwinds
   always @(negedge fl_reset_n) if (!ready_busy_n) begin
      mem.delete(pend);
      busy_end = $realtime + BUSY_NS / 2;
   end
   always #1 begin
      ok = $realtime >= acc_end;
      ready_busy_n = $realtime >= busy_end;
   end
endmodule // dbfc_flash_model

// ### verilog/dbfc_ctrl.v
// host side controller that drives the flash strobes, address and data
// Behaviour
// - read: select and output low, write high
// - write: write and select low, output high
// - short program mode needs two writes
// - host restarts operations cut by reset; the controller does not, the user re-issues them
// - wait recovery time after reset release
`timescale 1ns/1ps
`include "dbfc_map.vh"
module dbfc_ctrl #(
   parameter AW = 18,
   parameter RP_CYC = `DBFC_CYC_UP(`DBFC_RP_NS),
   parameter RH_CYC = `DBFC_CYC_UP(`DBFC_RH_NS)
) (
   input wire sys_clk, // 250 MHz clock
   input wire nrst, // async reset, active low
   input wire req_valid, // user request strobe
   input wire [1:0] req_cmd, // read, write or reset
   input wire [AW-1:0] req_addr, // word address
   input wire req_lsb, // byte lane address in byte mode
   input wire [15:0] req_wdata, // write data
   input wire word_mode, // 1 word, 0 byte width
   output reg req_ready, // idle and may take request
   output reg rsp_valid, // read data pulse
   output reg [15:0] rsp_rdata, // read data
   output reg bank_busy, // ready_busy_n seen low
   output reg [AW-1:0] fl_addr, // flash address pins
   output reg fl_ce_n, // chip enable
   output reg fl_oe_n, // output enable
   output reg fl_we_n, // write enable
   output reg fl_reset_n, // hardware reset pin
   output reg fl_word, // width select pin
   output reg [15:0] fl_dq_out, // data pins out
   output reg fl_dq_lo_oe, // enable for data lines 0..7
   output reg fl_dq_hi_oe, // enable for lines 8..14
   output reg fl_top_oe, // enable for top_data_line
   input wire [15:0] fl_dq_in, // data pins in
   input wire ready_busy_n // device ready/busy
);
   localparam ST_IDLE = 3'h0;
   localparam ST_RD = 3'h1;
   localparam ST_WR = 3'h2;
   localparam ST_WHOLD = 3'h3;
   localparam ST_RST = 3'h4;
   localparam ST_RWAIT = 3'h5;
   localparam ST_REC = 3'h6;
   localparam TW = 10;
   localparam integer ACC_N = `DBFC_CYC_UP(`DBFC_ACC_NS);
   localparam integer WP_N = `DBFC_CYC_UP(`DBFC_WP_NS);
   localparam integer SU_N = `DBFC_CYC_UP(`DBFC_SETUP_NS);
   localparam integer RP_N = RP_CYC;
   localparam integer RH_N = RH_CYC;
   // counts cut to the timer width on purpose
   localparam [TW-1:0] ACC_CYC = ACC_N[TW-1:0];
   localparam [TW-1:0] WP_CYC = WP_N[TW-1:0];
   localparam [TW-1:0] SU_CYC = SU_N[TW-1:0];
   localparam [TW-1:0] RPC = RP_N[TW-1:0];
   localparam [TW-1:0] RHC = RH_N[TW-1:0];

   reg [2:0] state_reg;
   reg tload;
   reg [TW-1:0] tcount;
   wire tdone;

   dbfc_timer #(.W(TW)) u_tmr (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );

   // main sequencer; reads wait the full select access time each cycle
   // since the host cannot tell standby or sleep from active
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         // power-up also gives the flash a full reset pulse and recovery,
         // since the system reset alone may be shorter than the minimum
         state_reg <= ST_RST;
         tload <= 1'b1;
         tcount <= RPC;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         bank_busy <= 1'b0;
         fl_addr <= {AW{1'b0}};
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
         fl_reset_n <= 1'b0;
         fl_word <= 1'b1;
         fl_dq_out <= 16'h0000;
         fl_dq_lo_oe <= 1'b0;
         fl_dq_hi_oe <= 1'b0;
         fl_top_oe <= 1'b0;
      end else begin
         tload <= 1'b0;
         rsp_valid <= 1'b0;
         bank_busy <= ~ready_busy_n;
         case (state_reg)
            ST_IDLE: begin
               fl_reset_n <= 1'b1;
               fl_ce_n <= 1'b1;
               fl_oe_n <= 1'b1;
               fl_we_n <= 1'b1;
               fl_dq_lo_oe <= 1'b0;
               fl_dq_hi_oe <= 1'b0;
               fl_top_oe <= 1'b0;
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  fl_addr <= req_addr;
                  fl_word <= word_mode;
                  // byte mode: top line carries the low address bit
                  fl_top_oe <= ~word_mode;
                  fl_dq_out <= {req_lsb, 15'h0000};
                  tload <= 1'b1;
                  case (req_cmd)
                     `DBFC_CMD_READ: begin
                        fl_ce_n <= 1'b0;
                        fl_oe_n <= 1'b0;
                        tcount <= ACC_CYC;
                        state_reg <= ST_RD;
                     end
                     `DBFC_CMD_WRITE: begin
                        fl_ce_n <= 1'b0;
                        fl_we_n <= 1'b0;
                        fl_dq_lo_oe <= 1'b1;
                        fl_dq_hi_oe <= word_mode;
                        fl_top_oe <= 1'b1;
                        fl_dq_out <= word_mode ? req_wdata :
                           {req_lsb, 7'h00, req_wdata[7:0]};
                        // one request is one command cycle, so a short
                        // program takes exactly two requests
                        tcount <= WP_CYC;
                        state_reg <= ST_WR;
                     end
                     `DBFC_CMD_RESET: begin
                        fl_reset_n <= 1'b0;
                        fl_top_oe <= 1'b0;
                        tcount <= RPC;
                        state_reg <= ST_RST;
                     end
                     default: begin
                        tload <= 1'b0;
                        req_ready <= 1'b1;
                     end
                  endcase
               end
            end
            ST_RD: begin
               if (tdone) begin
                  // byte mode answers only on the low lanes
                  rsp_rdata <= fl_word ? fl_dq_in :
                     {8'h00, fl_dq_in[7:0]};
                  rsp_valid <= 1'b1;
                  fl_ce_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_WR: begin
               if (tdone) begin
                  fl_we_n <= 1'b1; // data held one hold period after
                  tload <= 1'b1;
                  tcount <= SU_CYC;
                  state_reg <= ST_WHOLD;
               end
            end
            ST_WHOLD: begin
               if (tdone) begin
                  fl_ce_n <= 1'b1;
                  fl_dq_lo_oe <= 1'b0;
                  fl_dq_hi_oe <= 1'b0;
                  fl_top_oe <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_RST: begin
               if (tdone) begin
                  fl_reset_n <= 1'b1;
                  state_reg <= ST_RWAIT;
               end
            end
            ST_RWAIT: begin
               // wait for busy to clear, then the recovery interval
               if (ready_busy_n) begin
                  tload <= 1'b1;
                  tcount <= RHC;
                  state_reg <= ST_REC;
               end
            end
            ST_REC: begin
               if (tdone) begin
                  // idle again: the user re-issues any cut operation
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // dbfc_ctrl

// ### verilog/dbfc_map.vh
// timing and field constants for the dual bank flash host controller
`ifndef DBFC_MAP_VH
`define DBFC_MAP_VH
// command codes for the host user port
`define DBFC_CMD_READ 2'h0
`define DBFC_CMD_WRITE 2'h1
`define DBFC_CMD_RESET 2'h2
// bank select bit position in the word address
`define DBFC_BANK_BIT 17
// clock period and times in ns
`define DBFC_CLK_NS 4
`define DBFC_ACC_NS 70
`define DBFC_OE_NS 30
`define DBFC_WP_NS 35
`define DBFC_SETUP_NS 8
`define DBFC_RP_NS 500
`define DBFC_RH_NS 50
`define DBFC_SLEEP_EXTRA_NS 30
// cycle counts: least times round up
`define DBFC_CYC_UP(t) (((t) + `DBFC_CLK_NS - 1) / `DBFC_CLK_NS)
`endif

// ### verilog/dbfc_timer.v
// down counter that reports when a loaded interval has elapsed
`timescale 1ns/1ps
module dbfc_timer #(
   parameter W = 10
) (
   input wire sys_clk, // system clock
   input wire nrst, // async reset, active low
   input wire load, // one-cycle load pulse
   input wire [W-1:0] count, // cycles to wait
   output wire done // high once interval elapsed
);
   reg [W-1:0] cnt_reg;

   // count down to zero, reload on demand
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= {W{1'b0}};
      end else if (load) begin
         cnt_reg <= count;
      end else if (cnt_reg != {W{1'b0}}) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (cnt_reg == {W{1'b0}}) && !load;
endmodule // dbfc_timer
